// ==== inc/asp_regs.vh ====
// constants for the async serial port core: field positions, reset values
// and bit timing counts; plain defines, no logic
`ifndef ASP_REGS_VH
`define ASP_REGS_VH

// multinode mode field positions
`define ASP_MN_NINTH_BIT 0
`define ASP_MN_ADDR_CMP 1

// oversampling: sixteen baud ticks per bit period
`define ASP_OSR_LAST 4'hF
`define ASP_OSR_MID 4'h7
// infrared pulse width in baud ticks (three sixteenths of a bit)
`define ASP_IR_PULSE 4'h3
// infrared decoder hold time in baud ticks
`define ASP_IR_HOLD 5'h10

// reset values
`define ASP_RST_BYTE 8'h00
`define ASP_RST_BAUD 16'h0000
`define ASP_RST_PHASE 4'h0
`define ASP_RST_BITS 3'h0

`endif

// ==== core/asp_brg.v ====
// baud generator: 16-bit down counter with reload, one tick per wrap
// assumes reload is held stable by the owner; a reload of 0 acts as 1
`timescale 1ns/10ps
`include "asp_regs.vh"

module asp_brg (
   input wire clk,
   input wire rst,
   input wire ce,
   input wire [15:0] reload,
   output reg [15:0] count_q,
   output reg tick_q
);

   always @(posedge clk) begin
      if (rst) begin
         count_q <= `ASP_RST_BAUD;
         tick_q <= 1'b0;
      end else if (ce) begin
         // wrap at one so the period is exactly reload clocks
         if (count_q <= 16'h0001) begin
            count_q <= reload;
            tick_q <= 1'b1;
         end else begin
            count_q <= count_q - 16'h0001;
            tick_q <= 1'b0;
         end
      end
   end

endmodule // asp_brg

// ==== core/asp_core.v ====
// async serial port core: transmitter, receiver, baud generator hookup,
// parity, nine-bit multinode addressing, driver enable and infrared path
// assumes config ports are steady during a character and rxd is
// synchronous to clk
//
// How it works
// - characters carry eight data bits, least significant bit first.
// - with parity on outside nine-bit mode, a parity bit of the chosen sense follows the data.
// - a low start bit opens each character and one or two high stops end it.
// - in nine-bit mode the ninth bit sent is the ninth-bit transmit value.
// - driver enable is active high when its polarity bit is 0, else low.
// - receiver off and baud control 1 raise an irq at each count to zero.
// - baud control 0 shows the reload value and raises no zero irq.
// - receiver on and baud control 1 show the live down count.
// - high and low count bytes are sampled each on its own, no latching.
// - irq select 0 flags data, errors and baud zero; select 1 flags errors and baud zero, not data.
// - infrared enable routes both directions through the ir codec.
// - with address compare set, only matching addresses pass data and the data irq; frame errors still raise irq.
// - one bit lasts divisor times sixteen clocks.
// - the receiver irq pending output is 1 while a request waits.
`timescale 1ns/10ps
`include "asp_regs.vh"

module asp_core (
   input wire clk,
   input wire rst,
   input wire ce,
   input wire rx_enable,
   input wire parity_enable,
   input wire parity_odd,
   input wire two_stop,
   input wire [1:0] multinode_mode_field,
   input wire ninth_bit_tx_value,
   input wire driver_enable_polarity,
   input wire baud_gen_control,
   input wire rx_data_irq_select,
   input wire infrared_codec_enable,
   input wire [7:0] node_address,
   input wire [15:0] baud_reload,
   input wire [7:0] tx_data,
   input wire tx_valid,
   output reg tx_ready_q,
   input wire rx_ack,
   input wire irq_clear,
   input wire rxd,
   output reg txd_q,
   output reg line_driver_enable_q,
   output reg [7:0] rx_data_q,
   output reg rx_data_available_q,
   output reg rx_ninth_q,
   output reg rx_parity_err_q,
   output reg rx_frame_err_q,
   output reg rx_overrun_q,
   output reg serial_rx_irq_pending_q,
   output reg [7:0] baud_read_hi_q,
   output reg [7:0] baud_read_lo_q
);

   localparam S_IDLE = 5'b00001;
   localparam S_START = 5'b00010;
   localparam S_DATA = 5'b00100;
   localparam S_NINTH = 5'b01000;
   localparam S_STOP = 5'b10000;

   function par_bit;
      input [7:0] data;
      input odd;
      begin
         par_bit = (^data) ^ odd;
      end
   endfunction

   wire [15:0] brg_count;
   wire tick;
   wire mode9 = multinode_mode_field[`ASP_MN_NINTH_BIT];
   wire addr_cmp = multinode_mode_field[`ASP_MN_ADDR_CMP];
   wire has_ninth = mode9 | parity_enable;

   asp_brg u_brg (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .reload(baud_reload),
      .count_q(brg_count),
      .tick_q(tick)
   );

   // =====================================================
   // transmitter
   reg [4:0] tx_st_q;
   reg [3:0] tx_ph_q;
   reg [2:0] tx_bits_q;
   reg [7:0] tx_sh_q;
   reg [7:0] tx_hold_q;
   reg tx_ninth_q;
   reg tx_stop2_q;
   reg tx_bit;
   reg tx_busy_d;
   wire tx_take = tx_valid & tx_ready_q;
   wire tx_bit_end = tick & (tx_ph_q == `ASP_OSR_LAST);
   wire tx_load = (tx_st_q == S_IDLE) & ~tx_ready_q;
   wire tx_last_stop = (tx_st_q == S_STOP) & tx_bit_end & ~tx_stop2_q;

   always @* begin
      case (tx_st_q)
         S_IDLE: tx_bit = 1'b1;
         S_START: tx_bit = 1'b0;
         S_DATA: tx_bit = tx_sh_q[0];
         S_NINTH: tx_bit = tx_ninth_q;
         S_STOP: tx_bit = 1'b1;
         default: tx_bit = 1'b1;
      endcase
      // busy until the final stop of the last queued character
      tx_busy_d = (tx_st_q != S_IDLE) | ~tx_ready_q;
      if (tx_last_stop & tx_ready_q & ~tx_valid)
         tx_busy_d = 1'b0;
   end

   always @(posedge clk) begin
      if (rst) begin
         tx_st_q <= S_IDLE;
         tx_ph_q <= `ASP_RST_PHASE;
         tx_bits_q <= `ASP_RST_BITS;
         tx_sh_q <= `ASP_RST_BYTE;
         tx_hold_q <= `ASP_RST_BYTE;
         tx_ninth_q <= 1'b0;
         tx_stop2_q <= 1'b0;
         tx_ready_q <= 1'b1;
         txd_q <= 1'b1;
         line_driver_enable_q <= 1'b0;
      end else if (ce) begin
         if (tx_take) begin
            tx_hold_q <= tx_data;
            tx_ready_q <= 1'b0;
         end
         if (tick)
            tx_ph_q <= tx_ph_q + 4'h1;
         case (tx_st_q)
            S_IDLE: begin
               tx_ph_q <= `ASP_RST_PHASE;
               if (tx_load) begin
                  tx_sh_q <= tx_hold_q;
                  // ninth bit wins over parity in nine-bit mode
                  tx_ninth_q <= mode9 ? ninth_bit_tx_value :
                     par_bit(tx_hold_q, parity_odd);
                  tx_ready_q <= 1'b1;
                  tx_st_q <= S_START;
               end
            end
            S_START: begin
               tx_bits_q <= `ASP_RST_BITS;
               if (tx_bit_end)
                  tx_st_q <= S_DATA;
            end
            S_DATA: begin
               if (tx_bit_end) begin
                  tx_sh_q <= {1'b0, tx_sh_q[7:1]};
                  tx_bits_q <= tx_bits_q + 3'h1;
                  if (tx_bits_q == 3'h7) begin
                     tx_st_q <= has_ninth ? S_NINTH : S_STOP;
                     tx_stop2_q <= two_stop;
                  end
               end
            end
            S_NINTH: begin
               if (tx_bit_end)
                  tx_st_q <= S_STOP;
            end
            S_STOP: begin
               if (tx_bit_end) begin
                  tx_stop2_q <= 1'b0;
                  if (~tx_stop2_q) begin
                     // chain straight into the queued byte, no idle gap
                     if (~tx_ready_q | tx_valid) begin
                        tx_sh_q <= tx_ready_q ? tx_data : tx_hold_q;
                        tx_ninth_q <= mode9 ? ninth_bit_tx_value :
                           par_bit(tx_ready_q ? tx_data : tx_hold_q,
                           parity_odd);
                        tx_ready_q <= 1'b1;
                        tx_st_q <= S_START;
                     end else begin
                        tx_st_q <= S_IDLE;
                     end
                  end
               end
            end
            default: tx_st_q <= S_IDLE;
         endcase
         // ir encoder: short high pulse for a zero, line low otherwise
         if (infrared_codec_enable)
            txd_q <= ~tx_bit & (tx_st_q != S_IDLE) &
               (tx_ph_q < `ASP_IR_PULSE);
         else
            txd_q <= tx_bit;
         line_driver_enable_q <= tx_busy_d ^ driver_enable_polarity;
      end
   end

   // =====================================================
   // infrared decoder
   // a received pulse marks a zero; hold low for one bit time so the
   // sampler at mid bit sees it, at the cost of one bit of latency jitter
   reg [4:0] ir_hold_q;
   wire rx_in = infrared_codec_enable ? (ir_hold_q == 5'h00) : rxd;

   always @(posedge clk) begin
      if (rst) begin
         ir_hold_q <= 5'h00;
      end else if (ce) begin
         if (rxd & infrared_codec_enable)
            ir_hold_q <= `ASP_IR_HOLD;
         else if (tick & (ir_hold_q != 5'h00))
            ir_hold_q <= ir_hold_q - 5'h01;
      end
   end

   // =====================================================
   // receiver
   reg [4:0] rx_st_q;
   reg [3:0] rx_ph_q;
   reg [2:0] rx_bits_q;
   reg [7:0] rx_sh_q;
   reg rx_ninth_bit_q;
   reg addr_match_q;
   reg rx_done;
   reg rx_accept;
   reg rx_perr;
   reg rx_ferr;
   reg rx_is_addr;
   wire rx_bit_end = tick & (rx_ph_q == `ASP_OSR_LAST);
   wire brg_zero_irq = tick & ~rx_enable & baud_gen_control;

   always @* begin
      rx_done = (rx_st_q == S_STOP) & rx_bit_end;
      rx_ferr = rx_done & ~rx_in;
      rx_is_addr = mode9 & rx_ninth_bit_q;
      rx_perr = rx_done & parity_enable & ~mode9 &
         (par_bit(rx_sh_q, parity_odd) != rx_ninth_bit_q);
      if (~addr_cmp)
         rx_accept = rx_done;
      else if (rx_is_addr)
         rx_accept = rx_done & (rx_sh_q == node_address);
      else
         rx_accept = rx_done & addr_match_q;
   end

   always @(posedge clk) begin
      if (rst) begin
         rx_st_q <= S_IDLE;
         rx_ph_q <= `ASP_RST_PHASE;
         rx_bits_q <= `ASP_RST_BITS;
         rx_sh_q <= `ASP_RST_BYTE;
         rx_ninth_bit_q <= 1'b0;
         addr_match_q <= 1'b0;
         rx_data_q <= `ASP_RST_BYTE;
         rx_data_available_q <= 1'b0;
         rx_ninth_q <= 1'b0;
         rx_parity_err_q <= 1'b0;
         rx_frame_err_q <= 1'b0;
         rx_overrun_q <= 1'b0;
         serial_rx_irq_pending_q <= 1'b0;
         baud_read_hi_q <= `ASP_RST_BYTE;
         baud_read_lo_q <= `ASP_RST_BYTE;
      end else if (ce) begin
         if (tick)
            rx_ph_q <= rx_ph_q + 4'h1;
         case (rx_st_q)
            S_IDLE: begin
               rx_ph_q <= `ASP_RST_PHASE;
               if (rx_enable & ~rx_in)
                  rx_st_q <= S_START;
            end
            S_START: begin
               rx_bits_q <= `ASP_RST_BITS;
               rx_ninth_bit_q <= 1'b0;
               // recheck at mid bit to reject glitches
               if (tick & (rx_ph_q == `ASP_OSR_MID)) begin
                  rx_ph_q <= `ASP_RST_PHASE;
                  rx_st_q <= rx_in ? S_IDLE : S_DATA;
               end
            end
            S_DATA: begin
               if (rx_bit_end) begin
                  rx_sh_q <= {rx_in, rx_sh_q[7:1]};
                  rx_bits_q <= rx_bits_q + 3'h1;
                  if (rx_bits_q == 3'h7)
                     rx_st_q <= has_ninth ? S_NINTH : S_STOP;
               end
            end
            S_NINTH: begin
               if (rx_bit_end) begin
                  rx_ninth_bit_q <= rx_in;
                  rx_st_q <= S_STOP;
               end
            end
            S_STOP: begin
               if (rx_bit_end)
                  rx_st_q <= S_IDLE;
            end
            default: rx_st_q <= S_IDLE;
         endcase
         if (~rx_enable)
            rx_st_q <= S_IDLE;
         if (rx_done & rx_is_addr & addr_cmp)
            addr_match_q <= (rx_sh_q == node_address);
         if (rx_accept) begin
            rx_data_q <= rx_sh_q;
            rx_ninth_q <= rx_ninth_bit_q;
         end
         // hardware set wins over a same-cycle clear
         if (rx_accept)
            rx_data_available_q <= 1'b1;
         else if (rx_ack)
            rx_data_available_q <= 1'b0;
         if (rx_accept & rx_data_available_q & ~rx_ack)
            rx_overrun_q <= 1'b1;
         else if (rx_ack)
            rx_overrun_q <= 1'b0;
         if (rx_done) begin
            rx_parity_err_q <= rx_perr;
            rx_frame_err_q <= rx_ferr;
         end
         if ((rx_accept & ~rx_data_irq_select) | rx_perr | rx_ferr |
            (rx_accept & rx_data_available_q & ~rx_ack) | brg_zero_irq)
            serial_rx_irq_pending_q <= 1'b1;
         else if (irq_clear)
            serial_rx_irq_pending_q <= 1'b0;
         // each byte follows the live count, or the reload when baud control is 0, on its own every cycle
         if (baud_gen_control) begin
            baud_read_hi_q <= brg_count[15:8];
            baud_read_lo_q <= brg_count[7:0];
         end else begin
            baud_read_hi_q <= baud_reload[15:8];
            baud_read_lo_q <= baud_reload[7:0];
         end
      end
   end

endmodule // asp_core

// ==== verif/asp_core_assertions.sv ====
// checker for asp_core: timing relations between its ports
// assumes ce held high and baud_reload of 1 while characters are sent
`timescale 1ns/10ps
module asp_chk (
   input wire clk,
   input wire rst,
   input wire rx_enable,
   input wire driver_enable_polarity,
   input wire baud_gen_control,
   input wire rx_data_irq_select,
   input wire infrared_codec_enable,
   input wire [15:0] baud_reload,
   input wire txd_q,
   input wire line_driver_enable_q,
   input wire rx_data_available_q,
   input wire serial_rx_irq_pending_q,
   input wire [7:0] baud_read_hi_q,
   input wire [7:0] baud_read_lo_q
);
   wire [15:0] rd = {baud_read_hi_q, baud_read_lo_q};
   wire ir = infrared_codec_enable;
   wire irq = serial_rx_irq_pending_q;
   wire bgc = baud_gen_control;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // ====================
   // assertions
   // ir idle is low, so a mode switch needs a cycle of grace
   chk_de_level: assert property (
      !txd_q && !ir && !$past(ir) && !$past(rst)
      |-> line_driver_enable_q != driver_enable_polarity)
      else $error("driver enable idle in frame");
   chk_reload_view: assert property (
      !bgc && !$past(bgc) && !$past(rst) |-> rd == $past(baud_reload))
      else $error("baud read not reload");
   chk_live_count: assert property (
      bgc && $past(bgc) && $past(bgc, 2) && !$past(rst) && !$past(rst, 2)
      && baud_reload > 16'h0001 && $past(baud_reload, 2) > 16'h0001
      |-> rd != $past(rd))
      else $error("baud read not live");
   chk_zero_irq: assert property (
      (!rx_enable && bgc && baud_reload < 16'h0009)[*8] |-> ##[0:10] irq)
      else $error("no irq from baud zero");
   chk_irq_cause: assert property (
      $rose(irq) && !$past(rst) |-> $past(bgc) || $past(bgc, 2)
      || $past(rx_enable) || $past(rx_enable, 2))
      else $error("irq without cause");
   chk_data_irq: assert property (
      $rose(rx_data_available_q) && !rx_data_irq_select |-> irq)
      else $error("data without irq");
   chk_bit_hold: assert property (
      $changed(txd_q) && !ir && !$past(ir) && !$past(rst)
      && baud_reload == 16'h0001
      |=> $stable(txd_q)[*8] ##1 $stable(txd_q)[*7])
      else $error("bit shorter than 16 clocks");
   chk_ir_pulse: assert property (
      $rose(txd_q) && ir && $past(ir) && baud_reload == 16'h0001
      |-> txd_q[*3] ##1 !txd_q)
      else $error("ir pulse not 3 ticks");
endmodule // asp_chk

bind asp_core asp_chk asp_chk_i (.clk, .rst, .rx_enable,
   .driver_enable_polarity, .baud_gen_control, .rx_data_irq_select,
   .infrared_codec_enable, .baud_reload, .txd_q, .line_driver_enable_q,
   .rx_data_available_q, .serial_rx_irq_pending_q, .baud_read_hi_q,
   .baud_read_lo_q);

// ==== verif/asp_remote.sv ====
// remote serial node: drives the receive line with one framed character
// assumes frame and len are set before go is pulsed for one clock
`timescale 1ns/10ps
module asp_remote #(parameter BIT = 16) (
   input wire clk,
   input wire go,
   input wire [15:0] frame,
   input wire [4:0] len,
   output reg rxd
);
   integer k;
   // line rests at mark level, high, between characters
   initial begin
      rxd = 1'b1;
      forever begin
         @(posedge clk);
         if (go) begin
            for (k = 0; k < len; k = k + 1) begin
               rxd <= frame[k];
               repeat (BIT) @(posedge clk);
            end
            rxd <= 1'b1;
         end
      end
   end
endmodule // asp_remote

// ==== verif/tb_asp_core.sv ====
// bench for asp_core: framing, parity, ninth bit, address match,
// infrared loopback, baud read views and receive irq
`timescale 1ns/10ps
module tb_asp_core;
   reg clk, rst, rx_enable, parity_enable, parity_odd, two_stop, go, ir_lb;
   reg ninth_bit_tx_value, driver_enable_polarity, baud_gen_control;
   reg rx_data_irq_select, infrared_codec_enable, tx_valid, rx_ack;
   reg irq_clear, h9;
   reg [1:0] multinode_mode_field;
   reg [7:0] node_address, tx_data;
   reg [15:0] baud_reload, frame, c;
   reg [4:0] len;
   wire tx_ready_q, txd_q, line_driver_enable_q, rx_data_available_q;
   wire rx_ninth_q, rx_parity_err_q, rx_frame_err_q, remote_rxd;
   wire serial_rx_irq_pending_q, rx_overrun_q;
   wire [7:0] rx_data_q, baud_read_hi_q, baud_read_lo_q;
   wire rxd = ir_lb ? txd_q : remote_rxd;
   integer failures = 0, n_checks = 0, cyc = 0, i;
   // rows: parity, odd, two stops, nine-bit, ninth value, ninth seen, data
   reg [13:0] rows [0:6] = '{14'h00A5, 14'h283C, 14'h3181, 14'h0F5A,
      14'h34FF, 14'h2107, 14'h3100};
   asp_core asp_core_i (.clk, .rst, .ce(1'b1), .rx_enable, .parity_enable,
      .parity_odd, .two_stop, .multinode_mode_field, .ninth_bit_tx_value,
      .driver_enable_polarity, .baud_gen_control, .rx_data_irq_select,
      .infrared_codec_enable, .node_address, .baud_reload, .tx_data,
      .tx_valid, .tx_ready_q, .rx_ack, .irq_clear, .rxd, .txd_q,
      .line_driver_enable_q, .rx_data_q, .rx_data_available_q, .rx_ninth_q,
      .rx_parity_err_q, .rx_frame_err_q, .rx_overrun_q,
      .serial_rx_irq_pending_q, .baud_read_hi_q, .baud_read_lo_q);
   asp_remote asp_remote_i (.clk, .go, .frame, .len, .rxd(remote_rxd));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         failures = failures + 1;
         test_done;
      end
   end
   // ====================
   // tasks
   task tick(input integer k);
      begin
         repeat (k) @(posedge clk);
         #1;
      end
   endtask
   task chk(input [15:0] got, input [15:0] exp);
      begin
         n_checks = n_checks + 1;
         if (got !== exp) begin
            failures = failures + 1;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task test_done;
      begin
         $display("checks %0d failures %0d", n_checks, failures);
         if (failures == 0 && n_checks > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask
   task mk(input [7:0] d, input h, input b9, input t);
      begin
         frame = 16'hFFFF;
         frame[8:0] = {d, 1'b0};
         if (h) frame[9] = b9;
         len = 5'd10 + {4'h0, h} + {4'h0, t};
      end
   endtask
   task txs(input [7:0] d);
      integer k;
      begin
         tx_data = d;
         tx_valid = 1'b1;
         for (k = 0; k < 400 && tx_ready_q !== 1'b1; k = k + 1) tick(1);
         tick(1);
         tx_valid = 1'b0;
      end
   endtask
   // samples mid-bit, one bit past the frame to catch the queued start
   task cap;
      integer k;
      begin
         c = 16'hFFFF;
         for (k = 0; k < 99 && txd_q !== 1'b0; k = k + 1) tick(1);
         tick(8);
         chk(line_driver_enable_q, !driver_enable_polarity);
         for (k = 0; k <= len; k = k + 1) begin
            c[k] = txd_q;
            if (k < len) tick(16);
         end
         chk(line_driver_enable_q, !driver_enable_polarity);
      end
   endtask
   task rxs;
      begin
         go = 1'b1;
         tick(1);
         go = 1'b0;
         tick(16 * len + 30);
      end
   endtask
   task clr;
      begin
         rx_ack = 1'b1;
         irq_clear = 1'b1;
         tick(1);
         rx_ack = 1'b0;
         irq_clear = 1'b0;
      end
   endtask
   task rxchk(input [7:0] d, input sel);
      begin
         chk({rx_data_available_q, rx_data_q}, {1'b1, d});
         chk({rx_parity_err_q, rx_frame_err_q}, 16'h0);
         chk(serial_rx_irq_pending_q, !sel);
         clr;
      end
   endtask
   // ====================
   // main sequence
   initial begin
      rst = 1'b1;
      {rx_enable, parity_enable, parity_odd, two_stop, go, ir_lb} = 6'h20;
      {ninth_bit_tx_value, driver_enable_polarity, baud_gen_control} = 3'h0;
      {rx_data_irq_select, infrared_codec_enable, tx_valid} = 3'h0;
      {rx_ack, irq_clear, multinode_mode_field} = 4'h0;
      {node_address, tx_data} = 16'h4200;
      baud_reload = 16'h0001;
      frame = 16'hFFFF;
      len = 5'h0;
      tick(6);
      rst = 1'b0;
      tick(1);
      chk({txd_q, tx_ready_q, serial_rx_irq_pending_q}, 16'h6);
      for (i = 0; i < 7; i = i + 1) begin
         {parity_enable, parity_odd, two_stop} = rows[i][13:11];
         multinode_mode_field = {1'b0, rows[i][10]};
         ninth_bit_tx_value = rows[i][9];
         driver_enable_polarity = i[0];
         h9 = rows[i][13] | rows[i][10];
         mk(rows[i][7:0], h9, rows[i][8], two_stop);
         tick(2);
         fork
            cap;
            begin
               txs(rows[i][7:0]);
               tick(1);
               txs(rows[i][7:0]);
            end
         join
         chk(c, frame & ~(16'h1 << len));
         tick(300);
         rxs;
         if (h9) chk(rx_ninth_q, rows[i][8]);
         rxchk(rows[i][7:0], 1'b0);
      end
      {parity_enable, two_stop, multinode_mode_field} = 4'h0;
      rx_data_irq_select = 1'b1;
      mk(8'h55, 1'b0, 1'b0, 1'b0);
      rxs;
      rxchk(8'h55, 1'b1);
      frame[9] = 1'b0;
      rxs;
      chk({rx_frame_err_q, serial_rx_irq_pending_q}, 16'h3);
      clr;
      rx_data_irq_select = 1'b0;
      multinode_mode_field = 2'b11;
      mk(8'h41, 1'b1, 1'b1, 1'b0);
      rxs;
      chk({rx_data_available_q, serial_rx_irq_pending_q}, 16'h0);
      mk(8'h10, 1'b1, 1'b0, 1'b0);
      rxs;
      chk({rx_data_available_q, serial_rx_irq_pending_q}, 16'h0);
      mk(8'h42, 1'b1, 1'b1, 1'b0);
      rxs;
      rxchk(8'h42, 1'b0);
      mk(8'h10, 1'b1, 1'b0, 1'b0);
      rxs;
      rxchk(8'h10, 1'b0);
      multinode_mode_field = 2'b00;
      // two characters with no ack between them must flag an overrun
      mk(8'h33, 1'b0, 1'b0, 1'b0);
      rxs;
      rxs;
      chk({rx_overrun_q, rx_data_q}, 16'h0133);
      chk(serial_rx_irq_pending_q, 1'b1);
      clr;
      // receiver off across the switch, else the idle flip looks like a start
      rx_enable = 1'b0;
      infrared_codec_enable = 1'b1;
      ir_lb = 1'b1;
      tick(40);
      rx_enable = 1'b1;
      tick(2);
      txs(8'hC3);
      tick(250);
      rxchk(8'hC3, 1'b0);
      rx_enable = 1'b0;
      infrared_codec_enable = 1'b0;
      ir_lb = 1'b0;
      tick(40);
      baud_reload = 16'h0004;
      baud_gen_control = 1'b1;
      tick(30);
      chk(serial_rx_irq_pending_q, 1'b1);
      baud_gen_control = 1'b0;
      tick(12);
      clr;
      tick(30);
      chk(serial_rx_irq_pending_q, 1'b0);
      chk({baud_read_hi_q, baud_read_lo_q}, 16'h0004);
      baud_reload = 16'h1234;
      tick(3);
      chk({baud_read_hi_q, baud_read_lo_q}, 16'h1234);
      rx_enable = 1'b1;
      baud_gen_control = 1'b1;
      tick(20);
      // live view: a down counter drops by one each clock at divisor 1234
      c = {baud_read_hi_q, baud_read_lo_q};
      tick(1);
      chk({baud_read_hi_q, baud_read_lo_q}, c - 16'h0001);
      test_done;
   end
endmodule // tb_asp_core
